/* File: core/io_reconfig_map.vh */
// Constants for the I/O reconfiguration sequencer (host side)
`ifndef IO_RECONFIG_MAP_VH
`define IO_RECONFIG_MAP_VH
`define CLK_PERIOD_PS 5000
`define HOLDOFF_US 230
`define HOLDOFF_CYC ((`HOLDOFF_US * 1000000 + `CLK_PERIOD_PS - 1) / `CLK_PERIOD_PS)
`define PULSE_MIN_NS 500
`define PULSE_CYC ((`PULSE_MIN_NS * 1000 + `CLK_PERIOD_PS - 1) / `CLK_PERIOD_PS)
`define TCK_HALF 4'h8
`define IR_LEN 10
`define IR_BYPASS 10'h3ff
`define IR_IO_RECONFIG 10'h00d
`define IR_PULSE_RECONFIG 10'h001
`define IR_PARK 10'h2d0
`define IR_RESUME 10'h2b0
`define OP_IO_RECONFIG 3'h0
`define OP_PARK 3'h1
`define OP_RESUME 3'h2
`define OP_PULSE_INSTR 3'h3
`define OP_PULSE_PIN 3'h4
`define OP_TAP_RESET 3'h5
`endif

/* File: core/tap_shifter.v */
// JTAG TAP driver: shifts one instruction or issues a TAP reset
`timescale 1ns/1ps
`include "io_reconfig_map.vh"
module tap_shifter (
    input wire core_clk, // 200 MHz clock
    input wire resetn, // Async reset, active low
    input wire start, // One-cycle request
    input wire do_reset, // Request is a TAP reset
    input wire [`IR_LEN-1:0] instr, // Instruction to load
    output reg busy_ff, // Sequence in progress
    output reg tck_ff, // Test clock out
    output reg tms_ff, // Test mode select
    output reg tdi_ff // Test data in
);
    reg [3:0] div_ff;
    reg [5:0] step_ff;
    reg [5:0] last_ff;
    reg [15:0] tms_seq_ff;
    reg [`IR_LEN-1:0] sh_ff;
    wire fall = busy_ff && tck_ff && div_ff == `TCK_HALF - 4'h1;
    wire rise = busy_ff && !tck_ff && div_ff == `TCK_HALF - 4'h1;
    always @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            busy_ff <= 1'b0;
            tck_ff <= 1'b0;
            tms_ff <= 1'b1;
            tdi_ff <= 1'b0;
            div_ff <= 4'h0;
            step_ff <= 6'h0;
            last_ff <= 6'h0;
            tms_seq_ff <= 16'h0;
            sh_ff <= {`IR_LEN{1'b0}};
        end else if (!busy_ff) begin
            div_ff <= 4'h0;
            if (start) begin
                busy_ff <= 1'b1;
                step_ff <= 6'h0;
                sh_ff <= instr;
                if (do_reset) begin
                    // Five TMS ones, then back to idle
                    tms_seq_ff <= 16'h001f;
                    last_ff <= 6'h6;
                end else begin
                    // Idle->SelDR->SelIR->Capture->Shift, shift, exit, upd
                    tms_seq_ff <= 16'hc006;
                    last_ff <= 6'h10;
                end
                tms_ff <= do_reset;
            end
        end else begin
            div_ff <= (div_ff == `TCK_HALF - 4'h1) ? 4'h0 : div_ff + 4'h1;
            if (rise)
                tck_ff <= 1'b1;
            if (fall) begin
                tck_ff <= 1'b0;
                if (step_ff == last_ff) begin
                    busy_ff <= 1'b0;
                    tms_ff <= 1'b0;
                end else begin
                    step_ff <= step_ff + 6'h1;
                    tms_ff <= tms_seq_ff[step_ff[3:0] + 4'h1];
                    // Bit 0 must stand before the first shift edge
                    if (step_ff >= 6'h4 && step_ff < 6'h4 + `IR_LEN) begin
                        tdi_ff <= sh_ff[0];
                        sh_ff <= {1'b0, sh_ff[`IR_LEN-1:1]};
                    end
                end
            end
        end
    end
endmodule // tap_shifter

/* File: core/jtag_io_reconfig_sequencer.v */
// Host-side sequencer that drives the device's I/O reconfiguration flow
// Operation
// - After testing, reconfigure by instruction or pin
// - Never load I/O instruction while pin low
// - Wait 230 us after pin release
// - Wait 230 us after pulse or resume
// - After power-up wait 230 us or status high
// - I/O instruction first, then trigger, TAP reset
// - Resume needs no extra reconfiguration pulse
// - Park controllers on interrupt, resume later
// - Park before I/O instruction if programming later
// - Normal-mode recovery needs no prior park
// - Reconfigure by pin low 500 ns or instruction
// - Failed programming after park needs resume
`timescale 1ns/1ps
`include "io_reconfig_map.vh"
module jtag_io_reconfig_sequencer (
    input wire core_clk, // 200 MHz clock
    input wire resetn, // Async reset, active low
    input wire cmd_valid, // Command request, one cycle
    input wire [2:0] cmd_op, // Command code
    input wire config_status_n_pin, // Device status pin
    output reg cmd_ready_ff, // Idle and able to take a command
    output reg cmd_done_ff, // Command finished, one cycle
    output reg cmd_refused_ff, // Command refused, one cycle
    output reg holdoff_ff, // Hold-off window running
    output reg reconfig_request_n_pin_ff, // Reconfig request pin out
    output wire tck, // Test clock
    output wire tms, // Test mode select
    output wire tdi // Test data in
);
    localparam S_IDLE = 2'h0;
    localparam S_SHIFT = 2'h1;
    localparam S_PIN = 2'h2;
    localparam S_WAIT = 2'h3;
    // Header values are 32 bits wide; keep only the counter bits
    localparam [31:0] HOLD_CYC_W = `HOLDOFF_CYC;
    localparam [31:0] PULSE_CYC_W = `PULSE_CYC;
    localparam [23:0] HOLD_CYC = HOLD_CYC_W[23:0];
    localparam [7:0] PULSE_CYC = PULSE_CYC_W[7:0];
    reg [1:0] state_ff;
    reg [2:0] op_ff;
    reg [23:0] hold_cnt_ff;
    reg [7:0] pulse_cnt_ff;
    reg [2:0] stat_sync_ff;
    reg stat_high_ff;
    reg start_ff;
    reg rst_req_ff;
    reg [`IR_LEN-1:0] instr_ff;
    reg restart_hold;
    reg power_up_ff;
    wire busy;
    wire tck_i;
    wire tms_i;
    wire tdi_i;
    wire take;
    wire io_block;
    wire pin_done;
    wire shift_done;
    wire trig_instr;
    wire hold_last;
    wire early_ok;
    assign tck = tck_i;
    assign tms = tms_i;
    assign tdi = tdi_i;
    assign take = cmd_valid && cmd_ready_ff;
    // Pin low check is a guard; the pin is only low while not ready
    assign io_block = holdoff_ff || !reconfig_request_n_pin_ff;
    assign pin_done = state_ff == S_PIN && pulse_cnt_ff == 8'h0;
    assign shift_done = state_ff == S_WAIT && !busy && !start_ff;
    assign trig_instr = op_ff == `OP_PULSE_INSTR || op_ff == `OP_RESUME;
    assign hold_last = hold_cnt_ff == HOLD_CYC - 24'h1;
    // Status-high release is for the power-up wait only
    assign early_ok = power_up_ff && stat_high_ff;
    tap_shifter u_tap (
        .core_clk(core_clk),
        .resetn(resetn),
        .start(start_ff),
        .do_reset(rst_req_ff),
        .instr(instr_ff),
        .busy_ff(busy),
        .tck_ff(tck_i),
        .tms_ff(tms_i),
        .tdi_ff(tdi_i)
    );
    // Status pin crosses in; first stage feeds only the second
    always @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            stat_sync_ff <= 3'h0;
            stat_high_ff <= 1'b0;
        end else begin
            stat_sync_ff <= {stat_sync_ff[1:0], config_status_n_pin};
            if (stat_sync_ff[1] == stat_sync_ff[2])
                stat_high_ff <= stat_sync_ff[2];
        end
    end
    always @* begin
        restart_hold = 1'b0;
        if (pin_done)
            restart_hold = 1'b1;
        if (shift_done && trig_instr)
            restart_hold = 1'b1;
    end
    // Hold-off starts at power-up and on each trigger; status high ends only the power-up one early
    always @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            hold_cnt_ff <= 24'h0;
            holdoff_ff <= 1'b1;
        end else if (restart_hold) begin
            hold_cnt_ff <= 24'h0;
            holdoff_ff <= 1'b1;
        end else if (holdoff_ff) begin
            hold_cnt_ff <= hold_cnt_ff + 24'h1;
            if (hold_last || early_ok)
                holdoff_ff <= 1'b0;
        end
    end
    // Any trigger ends the power-up window for good
    always @(posedge core_clk or negedge resetn) begin
        if (!resetn)
            power_up_ff <= 1'b1;
        else if (restart_hold)
            power_up_ff <= 1'b0;
    end
    always @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            state_ff <= S_IDLE;
            op_ff <= `OP_TAP_RESET;
            pulse_cnt_ff <= 8'h0;
            start_ff <= 1'b0;
            rst_req_ff <= 1'b0;
            instr_ff <= `IR_BYPASS;
            cmd_ready_ff <= 1'b0;
            cmd_done_ff <= 1'b0;
            cmd_refused_ff <= 1'b0;
            reconfig_request_n_pin_ff <= 1'b1;
        end else begin
            start_ff <= 1'b0;
            cmd_done_ff <= 1'b0;
            cmd_refused_ff <= 1'b0;
            case (state_ff)
            S_IDLE: begin
                cmd_ready_ff <= 1'b1;
                if (take) begin
                    cmd_ready_ff <= 1'b0;
                    op_ff <= cmd_op;
                    rst_req_ff <= cmd_op == `OP_TAP_RESET;
                    case (cmd_op)
                    `OP_IO_RECONFIG: begin
                        if (io_block) begin
                            // Never shift it while the device could drop it
                            cmd_refused_ff <= 1'b1;
                            cmd_ready_ff <= 1'b1;
                        end else begin
                            instr_ff <= `IR_IO_RECONFIG;
                            start_ff <= 1'b1;
                            state_ff <= S_WAIT;
                        end
                    end
                    `OP_PARK: begin
                        instr_ff <= `IR_PARK;
                        start_ff <= 1'b1;
                        state_ff <= S_WAIT;
                    end
                    `OP_RESUME: begin
                        instr_ff <= `IR_RESUME;
                        start_ff <= 1'b1;
                        state_ff <= S_WAIT;
                    end
                    `OP_PULSE_INSTR: begin
                        instr_ff <= `IR_PULSE_RECONFIG;
                        start_ff <= 1'b1;
                        state_ff <= S_WAIT;
                    end
                    `OP_PULSE_PIN: begin
                        reconfig_request_n_pin_ff <= 1'b0;
                        pulse_cnt_ff <= PULSE_CYC;
                        state_ff <= S_PIN;
                    end
                    `OP_TAP_RESET: begin
                        start_ff <= 1'b1;
                        state_ff <= S_WAIT;
                    end
                    default: begin
                        cmd_refused_ff <= 1'b1;
                        cmd_ready_ff <= 1'b1;
                    end
                    endcase
                end
            end
            S_PIN: begin
                if (pulse_cnt_ff == 8'h0) begin
                    reconfig_request_n_pin_ff <= 1'b1;
                    cmd_done_ff <= 1'b1;
                    state_ff <= S_IDLE;
                end else begin
                    pulse_cnt_ff <= pulse_cnt_ff - 8'h1;
                end
            end
            S_WAIT: begin
                // Shifter raises busy the cycle after start
                if (shift_done) begin
                    cmd_done_ff <= 1'b1;
                    state_ff <= S_IDLE;
                end
            end
            default: state_ff <= S_IDLE;
            endcase
        end
    end
endmodule // jtag_io_reconfig_sequencer

/* File: sim/seq_chk.sv */
// Port assertions for the I/O reconfiguration sequencer
`timescale 1ns/1ps
`include "io_reconfig_map.vh"
module seq_chk (
    input wire core_clk, // Clock
    input wire resetn, // Reset, active low
    input wire cmd_valid, // Command request
    input wire [2:0] cmd_op, // Command code
    input wire config_status_n_pin, // Status pin
    input wire cmd_ready_ff, // Ready level
    input wire cmd_done_ff, // Done pulse
    input wire cmd_refused_ff, // Refused pulse
    input wire holdoff_ff, // Hold-off level
    input wire reconfig_request_n_pin_ff, // Request pin
    input wire tck, // Test clock
    input wire tms, // Test mode select
    input wire tdi // Test data in
);
    default clocking @(posedge core_clk);
    endclocking
    default disable iff (!resetn);
    sequence take_io;
        cmd_valid && cmd_ready_ff && cmd_op == `OP_IO_RECONFIG;
    endsequence
    sequence hold_soon;
        ##[0:2] holdoff_ff;
    endsequence
    a_refuse_hold: assert property (take_io ##0 holdoff_ff
        |=> cmd_refused_ff) else $error("io taken in hold-off");
    a_accept_free: assert property (take_io ##0 !holdoff_ff
        |=> !cmd_refused_ff) else $error("free io refused");
    a_pulse_width: assert property ($rose(reconfig_request_n_pin_ff)
        |-> !$past(reconfig_request_n_pin_ff, 100)) else $error("pulse short");
    a_quiet_low: assert property (!reconfig_request_n_pin_ff
        |-> $stable(tck) && !cmd_ready_ff) else $error("scan in pin low");
    a_hold_pin: assert property ($rose(reconfig_request_n_pin_ff)
        |-> hold_soon) else $error("no hold-off after pin");
    a_done_ready: assert property (cmd_done_ff |=> cmd_ready_ff
        && !cmd_done_ff) else $error("not ready after done");
    a_refuse_bad: assert property (cmd_valid && cmd_ready_ff
        && cmd_op > `OP_TAP_RESET |=> cmd_refused_ff) else $error("bad op");
    a_scan_stable: assert property (tck && $past(tck)
        |-> $stable(tdi) && $stable(tms)) else $error("scan data moved");
endmodule // seq_chk
bind jtag_io_reconfig_sequencer seq_chk u_chk (.core_clk, .resetn,
    .cmd_valid, .cmd_op, .config_status_n_pin, .cmd_ready_ff, .cmd_done_ff,
    .cmd_refused_ff, .holdoff_ff, .reconfig_request_n_pin_ff, .tck, .tms,
    .tdi);

/* File: sim/dev_model.sv */
// Device model: TAP decode, hold-off and reconfiguration
`timescale 1ns/1ps
`include "io_reconfig_map.vh"
module dev_model (
    input wire tck, // Test clock
    input wire tms, // Test mode select
    input wire tdi, // Test data in
    input wire req_n, // Request pin
    output reg status_n = 1'b1 // Status pin
);
    reg [2:0] st = 3'h0;
    reg [2:0] ones = 3'h0;
    reg [9:0] sr = 10'h0;
    reg [9:0] ir = `IR_BYPASS;
    reg hiz = 1'b0;
    reg parked = 1'b0;
    integer reconf = 0;
    integer io_loads = 0;
    time t0 = 0;
    time t_rel = 0; // Zero means no trigger yet
    event trig;
    always @(trig) begin
        t_rel = $time;
        hiz = 1'b0;
        status_n = 1'b0;
        #1000 status_n = 1'b1;
    end
    always @(negedge req_n) t0 = $time;
    always @(posedge req_n) begin
        // A rise with no fall before it is the power-up settle
        if (t0 > 0) t_rel = $time;
        if ($time - t0 >= 500) begin
            reconf = reconf + 1;
            -> trig;
        end
    end
    task upd(input [9:0] code);
        begin
            if (code == `IR_IO_RECONFIG &&
                (t_rel == 0 || $time - t_rel >= 230000)) begin
                io_loads = io_loads + 1;
                hiz = 1'b1;
            end
            if (code == `IR_PARK) parked = 1'b1;
            if (code == `IR_RESUME) parked = 1'b0;
            if (code == `IR_RESUME || code == `IR_PULSE_RECONFIG) begin
                reconf = reconf + 1;
                -> trig;
            end
        end
    endtask
    // Data-register path folded into idle; only IR scans matter here
    always @(posedge tck) begin
        ones <= tms ? ones + {2'h0, ones != 3'h4} : 3'h0;
        case (st)
            3'h1: st <= tms ? 3'h2 : 3'h0;
            3'h2: st <= tms ? 3'h0 : 3'h3;
            3'h3, 3'h4: st <= tms ? 3'h5 : 3'h4;
            3'h5: st <= tms ? 3'h6 : 3'h4;
            default: st <= {2'h0, tms};
        endcase
        if (st == 3'h4) sr <= {tdi, sr[9:1]};
        if (st == 3'h6) ir <= sr;
        if (st == 3'h6) upd(sr);
        if (tms && ones == 3'h4) ir <= `IR_BYPASS;
        if (tms && ones == 3'h4) st <= 3'h0;
    end
endmodule // dev_model

/* File: sim/tb_top.sv */
// Self-checking bench for the I/O reconfiguration sequencer
`timescale 1ns/1ps
`include "io_reconfig_map.vh"
module tb_top;
    reg core_clk = 1'b0;
    reg resetn = 1'b0;
    reg cmd_valid = 1'b0;
    reg [2:0] cmd_op = 3'h0;
    wire config_status_n_pin, cmd_ready_ff, cmd_done_ff, cmd_refused_ff;
    wire holdoff_ff, reconfig_request_n_pin_ff, tck, tms, tdi;
    wire fin = cmd_done_ff | cmd_refused_ff;
    integer num_errors = 0;
    integer checked = 0;
    integer cyc = 0;
    integer n, k;
    reg refd;
    always #2.5 core_clk = ~core_clk;
    jtag_io_reconfig_sequencer u_dut (.core_clk, .resetn, .cmd_valid,
        .cmd_op, .config_status_n_pin, .cmd_ready_ff, .cmd_done_ff,
        .cmd_refused_ff, .holdoff_ff, .reconfig_request_n_pin_ff, .tck, .tms,
        .tdi);
    dev_model u_dev (.tck, .tms, .tdi, .req_n(reconfig_request_n_pin_ff),
        .status_n(config_status_n_pin));
    task chk(input [31:0] seen, input [31:0] exp, input [63:0] what);
        begin
            checked = checked + 1;
            if (seen !== exp) begin
                num_errors = num_errors + 1;
                $display("MISMATCH %0s exp %0h seen %0h", what, exp, seen);
            end
        end
    endtask
    task wrap_up;
        begin
            $display("checked %0d num_errors %0d", checked, num_errors);
            if (num_errors == 0 && checked > 0)
                $display("TB: PASS");
            else
                $display("TB: FAIL");
            $finish;
        end
    endtask
    always @(posedge core_clk) begin
        cyc = cyc + 1;
        if (cyc == 60000) begin
            num_errors = num_errors + 1;
            wrap_up;
        end
    end
    task cmd(input [2:0] op);
        begin
            while (cmd_ready_ff !== 1'b1) @(posedge core_clk);
            cmd_valid <= 1'b1;
            cmd_op <= op;
            @(posedge core_clk);
            cmd_valid <= 1'b0;
            for (n = 0; n < 3000 && fin !== 1'b1; n = n + 1)
                @(posedge core_clk);
            chk(fin, 1, "fin");
            refd = cmd_refused_ff;
            @(posedge core_clk);
        end
    endtask
    task s_power;
        begin
            chk(holdoff_ff, 1, "hold");
            cmd(`OP_IO_RECONFIG);
            chk(refd, 1, "ioref");
            cmd(`OP_TAP_RESET);
            for (k = 0; k < 20 && holdoff_ff; k = k + 1)
                @(posedge core_clk);
            chk(holdoff_ff, 0, "hold");
            cmd(`OP_IO_RECONFIG);
            chk(u_dev.ir, `IR_IO_RECONFIG, "ir");
            chk(u_dev.io_loads, 1, "ioload");
            chk(u_dev.hiz, 1, "hiz");
            chk(config_status_n_pin, 1, "stat");
            cmd(3'h7);
            chk(refd, 1, "badop");
        end
    endtask
    task s_pin;
        begin
            cmd(`OP_PULSE_PIN);
            chk(u_dev.reconf, 1, "reconf");
            chk(holdoff_ff, 1, "hold");
            cmd(`OP_IO_RECONFIG);
            chk(refd, 1, "ioref");
        end
    endtask
    task s_trig;
        begin
            cmd(`OP_PARK);
            chk(u_dev.parked, 1, "parked");
            for (k = 0; k < 2; k = k + 1) begin
                cmd(k ? `OP_RESUME : `OP_PULSE_INSTR);
                chk(u_dev.reconf, 2 + k, "reconf");
                chk(holdoff_ff, 1, "hold");
                cmd(`OP_IO_RECONFIG);
                chk(refd, 1, "ioref");
            end
            chk(u_dev.parked, 0, "parked");
        end
    endtask
    task s_wait;
        begin
            for (n = 0; n < 47000 && holdoff_ff; n = n + 1)
                @(posedge core_clk);
            chk(n > `HOLDOFF_CYC - 30, 1, "holdmin");
            chk(n <= `HOLDOFF_CYC, 1, "holdmax");
            cmd(`OP_IO_RECONFIG);
            chk(refd, 0, "ioref");
            chk(u_dev.io_loads, 2, "ioload");
        end
    endtask
    initial begin
        repeat (10) @(posedge core_clk);
        resetn <= 1'b1;
        repeat (2) @(posedge core_clk);
        s_power;
        s_pin;
        s_trig;
        s_wait;
        wrap_up;
    end
endmodule // tb_top
